// file: hdl/pfta_pkg.sv
// package: register map, fields, modes and timing for table access
package pfta_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_PTR_LOW = 5'h00;
  localparam logic [4:0] OFS_PTR_HIGH = 5'h04;
  localparam logic [4:0] OFS_PTR_UPPER = 5'h08;
  localparam logic [4:0] OFS_LATCH = 5'h0C;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_UNLOCK = 5'h14;
  localparam logic [4:0] OFS_CMD = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int PTR_W = 22;
  localparam int PTR_MSB = 21;
  localparam int UPPER_W = 6;
  localparam int CTRL_PGD = 7;
  localparam int CTRL_CONFIG_SPACE_SELECT = 6;
  localparam int CTRL_FREE = 4;
  localparam int CTRL_WRITE_ENABLE_GATE = 2;
  localparam int CTRL_WR = 1;
  localparam int CMD_OP = 2;
  localparam int STAT_BUSY = 2;
  localparam int HOLD_N = 8;

  // unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // reset values
  localparam logic [21:0] PTR_RST = 22'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LONG_TIME_US = 2000;
  localparam int LONG_CYCLES = LONG_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_KEEP = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_POST_DEC = 2'h2,
    MODE_PRE_INC = 2'h3
  } pfta_mode_t;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'h0,
    UNL_KEY1 = 2'h1,
    UNL_ARMED = 2'h2
  } pfta_unlock_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RD_ISSUE = 2'h1,
    ST_RD_WAIT = 2'h3,
    ST_LONG = 2'h2
  } pfta_state_t;

  // read request toward the array: word address, bit 20 = config space
  typedef struct packed {
    logic en;
    logic [20:0] word_addr;
  } pfta_rd_req_t;

  // long cycle request toward the array
  typedef struct packed {
    logic start;
    logic erase;
    logic [18:0] block;
    logic [63:0] data;
  } pfta_long_req_t;

endpackage : pfta_pkg

// file: hdl/pfta_table_access.sv
// table access: pointer, latch, holding registers and long cycles
//
// Our own choices: the Avalon-MM slave port and the address map.

module pfta_table_access
  import pfta_pkg::*;
#(
  parameter int LONG_CYC = LONG_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // program array
  output pfta_rd_req_t arr_rd,
  input wire logic [15:0] arr_rd_word,
  output pfta_long_req_t arr_long,
  // core
  output logic cpu_stall
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(LONG_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LONG_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [21:0] ptr_q;
  logic [7:0] latch_q;
  logic [7:0] hold_q [HOLD_N];
  logic pgd_q;
  logic config_space_select_q;
  logic free_q;
  logic write_enable_gate_q;
  logic wr_q;
  pfta_unlock_t unl_q;
  pfta_state_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  pfta_rd_req_t rd_q;
  pfta_long_req_t long_q;
  logic [21:0] eff_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // step the low part only, so the space select bit never moves
  function automatic logic [21:0] ptr_step(input logic [21:0] p,
                                           input logic down);
    logic [20:0] low;
    low = down ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001;
    return {p[PTR_MSB], low};
  endfunction

  function automatic logic [21:0] ptr_after(input logic [21:0] p,
                                            input pfta_mode_t m);
    logic [21:0] r;
    r = p;
    unique case (m)
      MODE_KEEP: r = p;
      MODE_POST_INC: r = ptr_step(p, 1'b0);
      MODE_POST_DEC: r = ptr_step(p, 1'b1);
      MODE_PRE_INC: r = ptr_step(p, 1'b0);
    endcase
    return r;
  endfunction

  // one decode for the latch, control, unlock and command write strobes, lane 0 only
  function automatic logic reg_wr(input logic take,
                                  input logic [3:0] be,
                                  input logic [4:0] a,
                                  input logic [4:0] ofs);
    return take && be[0] && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic busy;
  logic lane0;
  logic wr_cmd;
  logic cmd_is_rd;
  logic rd_hold;
  logic acc_wr;
  logic acc_rd;
  pfta_mode_t wmode;
  logic [21:0] weff;
  logic start_ok;
  logic wr_latch;
  logic wr_ctrl;
  logic wr_unlock;
  logic tmr_done;

  assign busy = (st_q == ST_LONG);
  assign lane0 = avs_byteenable[0];
  assign wmode = pfta_mode_t'(avs_writedata[1:0]);
  assign wr_cmd = reg_wr(avs_write, avs_byteenable, avs_address, OFS_CMD);
  assign wr_latch = reg_wr(acc_wr, avs_byteenable, avs_address, OFS_LATCH);
  assign wr_ctrl = reg_wr(acc_wr, avs_byteenable, avs_address, OFS_CTRL);
  assign wr_unlock = reg_wr(acc_wr, avs_byteenable, avs_address,
                            OFS_UNLOCK);
  // start and timer end never meet: the bus waits while busy
  assign tmr_done = busy && (cnt_q == CNT_ZERO);
  assign cmd_is_rd = !avs_writedata[CMD_OP];
  // pre-increment accesses the stepped address
  assign weff = (wmode == MODE_PRE_INC) ? ptr_step(ptr_q, 1'b0)
                                        : ptr_q;
  // a table read holds the bus until its one byte is back
  assign rd_hold = wr_cmd && cmd_is_rd && (st_q != ST_RD_WAIT);
  // long cycles stall every access, which stalls the core
  assign avs_waitrequest = busy || rd_hold || (avs_read && !rd_ack_q);
  assign acc_wr = avs_write && !avs_waitrequest;
  assign acc_rd = avs_read && !avs_waitrequest;
  assign avs_readdata = rdata_q;
  assign cpu_stall = busy;
  assign arr_rd = rd_q;
  assign arr_long = long_q;

  // start needs write enable and the armed unlock
  assign start_ok = wr_ctrl && avs_writedata[CTRL_WR] &&
                    write_enable_gate_q && pgd_q &&
                    (unl_q == UNL_ARMED) && !wr_q;

  // ----------------------------------------------------------------
  // pointer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ptr_q <= PTR_RST;
    end else if (acc_wr && lane0) begin
      unique case (avs_address)
        OFS_PTR_LOW: ptr_q[7:0] <= avs_writedata[7:0];
        OFS_PTR_HIGH: ptr_q[15:8] <= avs_writedata[7:0];
        OFS_PTR_UPPER: ptr_q[21:16] <= avs_writedata[5:0];
        OFS_CMD: ptr_q <= ptr_after(ptr_q, wmode);
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // table latch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      latch_q <= BYTE_RST;
    end else if (st_q == ST_RD_WAIT) begin
      // bit 0 picks the byte of the fetched word
      latch_q <= eff_q[0] ? arr_rd_word[15:8] : arr_rd_word[7:0];
    end else if (wr_latch) begin
      latch_q <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < HOLD_N; i++) begin
        hold_q[i] <= BYTE_RST;
      end
    end else if (acc_wr && wr_cmd && !cmd_is_rd) begin
      // short write: one holding register changes, the pointer steps per mode, no array cycle
      hold_q[weff[2:0]] <= latch_q;
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pgd_q <= 1'b0;
      config_space_select_q <= 1'b0;
      free_q <= 1'b0;
      write_enable_gate_q <= 1'b0;
    end else if (tmr_done) begin
      free_q <= 1'b0;
    end else if (wr_ctrl) begin
      pgd_q <= avs_writedata[CTRL_PGD];
      config_space_select_q <= avs_writedata[CTRL_CONFIG_SPACE_SELECT];
      free_q <= avs_writedata[CTRL_FREE];
      write_enable_gate_q <= avs_writedata[CTRL_WRITE_ENABLE_GATE];
    end
  end

  // write start: software can only set it, the timer clears it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_q <= 1'b0;
    end else if (start_ok) begin
      wr_q <= 1'b1;
    end else if (tmr_done) begin
      wr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  // keys land on a port that keeps no value
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      unl_q <= UNL_IDLE;
    end else if (acc_wr) begin
      if (wr_unlock) begin
        if (avs_writedata[7:0] == KEY_FIRST) begin
          unl_q <= UNL_KEY1;
        end else if (avs_writedata[7:0] == KEY_SECOND &&
                     unl_q == UNL_KEY1) begin
          unl_q <= UNL_ARMED;
        end else begin
          unl_q <= UNL_IDLE;
        end
      end else begin
        // any other write, start or not, uses up the arming
        unl_q <= UNL_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start_ok) begin
            st_q <= ST_LONG;
          end else if (rd_hold) begin
            st_q <= ST_RD_ISSUE;
          end
        end
        ST_RD_ISSUE: st_q <= ST_RD_WAIT;
        ST_RD_WAIT: st_q <= ST_IDLE;
        ST_LONG: begin
          if (cnt_q == CNT_ZERO) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // internal programming timer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= CNT_ZERO;
    end else if (start_ok) begin
      cnt_q <= CNT_LAST;
    end else if (busy && cnt_q != CNT_ZERO) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // effective address of the pending table read
  // held so the byte pick survives the pointer step at the end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      eff_q <= PTR_RST;
    end else if (st_q == ST_IDLE && rd_hold) begin
      eff_q <= weff;
    end
  end

  // ----------------------------------------------------------------
  // array requests
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_q <= '0;
    end else if (st_q == ST_IDLE && rd_hold) begin
      rd_q.en <= 1'b1;
      // pointer bits 21:1, top bit steers to id and config space
      rd_q.word_addr <= weff[21:1];
    end else begin
      rd_q.en <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      long_q <= '0;
    end else if (start_ok) begin
      long_q.start <= 1'b1;
      long_q.erase <= free_q;
      if (free_q) begin
        // whole 64-byte row only, no word or bulk erase
        long_q.block <= {ptr_q[21:6], 3'h0};
        long_q.data <= '0;
      end else begin
        long_q.block <= ptr_q[21:3];
        long_q.data <= {hold_q[7], hold_q[6], hold_q[5], hold_q[4],
                        hold_q[3], hold_q[2], hold_q[1], hold_q[0]};
      end
    end else begin
      long_q.start <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_ack_q <= 1'b0;
      rdata_q <= '0;
    end else if (avs_read && !rd_ack_q && !busy) begin
      rd_ack_q <= 1'b1;
      rdata_q <= '0;
      unique case (avs_address)
        OFS_PTR_LOW: rdata_q[7:0] <= ptr_q[7:0];
        OFS_PTR_HIGH: rdata_q[7:0] <= ptr_q[15:8];
        OFS_PTR_UPPER: rdata_q[5:0] <= ptr_q[21:16];
        OFS_LATCH: rdata_q[7:0] <= latch_q;
        OFS_CTRL: begin
          rdata_q[CTRL_PGD] <= pgd_q;
          rdata_q[CTRL_CONFIG_SPACE_SELECT] <= config_space_select_q;
          rdata_q[CTRL_FREE] <= free_q;
          rdata_q[CTRL_WRITE_ENABLE_GATE] <= write_enable_gate_q;
          rdata_q[CTRL_WR] <= wr_q;
        end
        OFS_STATUS: begin
          rdata_q[1:0] <= unl_q;
          rdata_q[STAT_BUSY] <= busy;
        end
        // unlock port, command and unmapped read as zero
        default: rdata_q <= '0;
      endcase
    end else if (acc_rd) begin
      rd_ack_q <= 1'b0;
    end
  end

endmodule // pfta_table_access

// file: dv/pfta_array_model.sv
// program array model answering word reads from the table logic
module pfta_array_model
  import pfta_pkg::*;
(
  // clock
  input wire logic mclk,
  // read port
  input wire pfta_rd_req_t arr_rd,
  output logic [15:0] arr_rd_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // high byte marks config space so the top pointer bit is visible
  always @(posedge mclk) begin
    if (arr_rd.en === 1'b1) begin
      arr_rd_word <= {arr_rd.word_addr[20] ? 8'hC3 :
        ~arr_rd.word_addr[7:0], arr_rd.word_addr[7:0]};
    end else begin
      // word only valid one cycle: toggle so stale use shows
      arr_rd_word <= ~arr_rd_word;
    end
  end
endmodule // pfta_array_model

// file: dv/pfta_sva.sv
// checker for the table access block ports
module pfta_sva
  import pfta_pkg::*;
#(
  parameter int LONG_CYC = LONG_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // array and core
  input wire pfta_rd_req_t arr_rd,
  input wire pfta_long_req_t arr_long,
  input wire logic cpu_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // helper: unlock progress and stall length
  // ------------------------------------------------------------
  logic [1:0] key_q;
  logic [31:0] stall_q;
  wire unl_w = avs_address == OFS_UNLOCK;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      key_q <= 2'h0;
    end else if (avs_write && !avs_waitrequest) begin
      key_q <= (unl_w && avs_writedata[7:0] == KEY_FIRST) ? 2'h1 :
        (key_q == 2'h1 && unl_w && avs_writedata[7:0] == KEY_SECOND) ?
        2'h2 : 2'h0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn || !cpu_stall) begin
      stall_q <= 32'h0;
    end else begin
      stall_q <= stall_q + 32'h1;
    end
  end
  sequence s_rd_done;
    !arr_rd.en && !avs_waitrequest;
  endsequence
  sequence s_long_go;
    $rose(cpu_stall) ##1 cpu_stall;
  endsequence
  a_rd_one_byte: assert property (arr_rd.en |=> !arr_rd.en)
    else $error("array read strobe longer than one cycle");
  a_rd_answer: assert property (arr_rd.en |=> s_rd_done)
    else $error("table read not answered after array word");
  a_start_stall: assert property (arr_long.start |-> s_long_go)
    else $error("long cycle start without stall");
  a_stall_len: assert property ($fell(cpu_stall) |->
    stall_q >= LONG_CYC && stall_q <= LONG_CYC + 1)
    else $error("stall length differs from timer");
  a_bus_held: assert property (cpu_stall && (avs_read || avs_write)
    |-> avs_waitrequest)
    else $error("bus access taken during long cycle");
  a_erase_blk: assert property (arr_long.start && arr_long.erase |->
    arr_long.block[2:0] == 3'h0 && arr_long.data == 64'h0)
    else $error("erase block not 64 byte aligned or data used");
  a_start_key: assert property (arr_long.start |->
    $past(key_q) == 2'h2)
    else $error("long cycle started without unlock");
  a_no_rd_long: assert property (cpu_stall |-> !arr_rd.en)
    else $error("array read during long cycle");
endmodule // pfta_sva

bind pfta_table_access pfta_sva #(.LONG_CYC(LONG_CYC)) u_sva (
  .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .arr_rd(arr_rd), .arr_long(arr_long), .cpu_stall(cpu_stall));

// file: dv/tb_program_flash_table_access.sv
// testbench for the table access block
module tb_program_flash_table_access
  import pfta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 20;
  logic mclk = 1'b0;
  logic resetn, avs_read, avs_write, avs_waitrequest, cpu_stall;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rq;
  logic [3:0] avs_byteenable;
  logic [15:0] arr_rd_word;
  pfta_rd_req_t arr_rd;
  pfta_long_req_t arr_long, lq;
  int fail_count, tests_run, n_start, nw;
  pfta_table_access #(.LONG_CYC(LC)) dut (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .arr_rd(arr_rd),
    .arr_rd_word(arr_rd_word), .arr_long(arr_long),
    .cpu_stall(cpu_stall));
  pfta_array_model u_arr (.mclk(mclk), .arr_rd(arr_rd),
    .arr_rd_word(arr_rd_word));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (!resetn) begin
      n_start <= 0;
    end else if (arr_long.start === 1'b1) begin
      lq <= arr_long;
      n_start <= n_start + 1;
    end
  end
  // ------------------------------------------------------------
  // bus and check helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one spare cycle after release keeps each signal to one update
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 600);
    rq = avs_readdata;
    nw = n;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    if (n >= 600) begin
      fail_count++;
      $display("CHECK FAILED %0t bus wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic set_ptr(input logic [21:0] p);
    wr(OFS_PTR_LOW, p[7:0]);
    wr(OFS_PTR_HIGH, p[15:8]);
    wr(OFS_PTR_UPPER, {2'h0, p[21:16]});
  endtask
  task automatic chk_ptr(input logic [21:0] p);
    rd(OFS_PTR_LOW);
    chk(rq, {24'h0, p[7:0]});
    rd(OFS_PTR_HIGH);
    chk(rq, {24'h0, p[15:8]});
    rd(OFS_PTR_UPPER);
    chk(rq, {26'h0, p[21:16]});
  endtask
  function automatic logic [21:0] stp(logic [21:0] p, logic [1:0] m);
    logic [20:0] l;
    l = p[20:0];
    if (m == 2'h1 || m == 2'h3) l = l + 21'h1;
    if (m == 2'h2) l = l - 21'h1;
    return {p[21], l};
  endfunction
  // key bytes then start; ctl already holds space and enable bits
  task automatic go(input logic [7:0] ctl, input logic mid);
    wr(OFS_CTRL, ctl);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    if (mid) wr(OFS_PTR_LOW, 8'h00);
    wr(OFS_CTRL, ctl | 8'h02);
    rd(OFS_CTRL);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk_ptr(22'h000000);
    set_ptr(22'h3FFFFF);
    chk_ptr(22'h3FFFFF);
    wr(OFS_UNLOCK, KEY_FIRST);
    rd(OFS_UNLOCK);
    chk(rq, 32'h0);
    rd(OFS_STATUS);
    chk(rq, 32'h1);
    rd(5'h01);
    chk(rq, 32'h0);
  endtask
  task automatic t_modes();
    logic [21:0] p, e;
    for (int i = 0; i < 8; i++) begin
      p = i[0] ? 22'h3FFFFF : 22'h000000;
      e = (i[2:1] == 2'h3) ? stp(p, 2'h3) : p;
      set_ptr(p);
      wr(OFS_CMD, {6'h0, i[2:1]});
      rd(OFS_LATCH);
      chk(rq, {24'h0, e[0] ? (e[21] ? 8'hC3 : ~e[8:1]) : e[8:1]});
      chk_ptr(stp(p, i[2:1]));
    end
  endtask
  task automatic t_long_write();
    logic [63:0] d;
    set_ptr(22'h00012D);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_LATCH, 8'h10 + k[7:0]);
      wr(OFS_CMD, 8'h05);
      d[8 * ((k + 5) % 8) +: 8] = 8'h10 + k[7:0];
    end
    go(8'h84, 1'b0);
    chk(rq, 32'h84);
    chk(n_start, 1);
    chk({31'h0, nw >= LC}, 32'h1);
    chk({13'h0, lq.block}, 32'h26);
    chk(lq.data[31:0], d[31:0]);
    chk(lq.data[63:32], d[63:32]);
  endtask
  task automatic t_erase();
    set_ptr(22'h01ABFF);
    wr(OFS_LATCH, 8'h5A);
    go(8'h94, 1'b0);
    chk(rq, 32'h84);
    chk(n_start, 2);
    chk({lq.erase, 12'h0, lq.block}, 32'h80003578);
    chk(lq.data[31:0], 32'h0);
    chk(lq.data[63:32], 32'h0);
  endtask
  task automatic t_refused();
    go(8'h80, 1'b0);
    chk(rq, 32'h80);
    chk(n_start, 2);
    go(8'h84, 1'b1);
    chk(rq, 32'h84);
    chk(n_start, 2);
    wr(OFS_CTRL, 8'h86);
    rd(OFS_CTRL);
    chk(rq, 32'h84);
    chk(n_start, 2);
  endtask
  initial begin
    resetn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    fail_count = 0;
    tests_run = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_modes();
    t_long_write();
    t_erase();
    t_refused();
    report_and_stop();
  end
endmodule // tb_program_flash_table_access
